// ### srm_device.sv
// Device end: serial register bank with control, status and id registers.
// Assumes CLK well above the link clock; link pins arrive asynchronously.
`timescale 1ns/1ps
module srm_device #(
    parameter logic [7:0] FAM_PROD_ID = 8'h5A // Arbitrary identity value
) (
    // Clock, reset, enable
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic CE,
    // Serial link
    srm_link_if.dev LINK,
    // Device-side updates of hardware-updatable bits, and restart
    input wire logic HW_UPD_VALID,
    input wire logic [4:0] HW_UPD_IDX,
    input wire logic [7:0] HW_UPD_DATA,
    input wire logic RESTART,
    // Status events and live levels
    input wire logic [srm_pkg::NUM_STAT*8-1:0] STAT_SET,
    input wire logic [7:0] WAKE_LEVELS,
    // Register contents and soft reset out
    output logic [srm_pkg::NUM_CTRL*8-1:0] CTRL_OUT,
    output logic SOFT_RESET_OUT
);
    localparam int NC = srm_pkg::NUM_CTRL;
    localparam int NS = srm_pkg::NUM_STAT;

    // Table lookups, used for both the read path and the commit
    function automatic logic [5:0] ctl_find(input logic [6:0] a);
        logic [5:0] r;
        r = 6'h00;
        for (int k = 0; k < NC; k++) begin
            if (srm_pkg::CTRL_ADDR[k] == a) begin
                r = {1'b1, 5'(k)};
            end
        end
        return r;
    endfunction

    function automatic logic [4:0] stat_find(input logic [6:0] a);
        logic [4:0] r;
        r = 5'h00;
        for (int k = 0; k < NS; k++) begin
            if (srm_pkg::STAT_ADDR[k] == a) begin
                r = {1'b1, 4'(k)};
            end
        end
        return r;
    endfunction

    logic [2:0] sclk_sy_ff;
    logic [2:0] cs_sy_ff;
    logic [1:0] mosi_sy_ff;
    srm_pkg::srm_dev_state_t state_ff;
    logic [15:0] shift_ff;
    logic [4:0] cnt_ff;
    logic [7:0] tx_ff;
    logic miso_ff;
    logic soft_rst_ff;
    logic [7:0] lvl_sy_ff;
    logic [7:0] lvl_ff;
    logic [7:0] ctl_ff [NC];
    logic [7:0] st_ff [NS];
    logic [7:0] nxt_ctl [NC];
    logic [7:0] nxt_st [NS];

    // Edges of the synchronised link pins; stage 0 feeds only stage 1
    wire sclk_rise = sclk_sy_ff[1] & ~sclk_sy_ff[2];
    wire sclk_fall = ~sclk_sy_ff[1] & sclk_sy_ff[2];
    wire cs_fall = ~cs_sy_ff[1] & cs_sy_ff[2];
    wire cs_rise = cs_sy_ff[1] & ~cs_sy_ff[2];
    wire shifting = (state_ff == srm_pkg::DEV_SHIFT) & ~cs_sy_ff[1];

    // First byte as it completes, LSB first
    wire [7:0] first_byte = {mosi_sy_ff[1], shift_ff[15:9]};
    wire addr_done = shifting & sclk_rise & (cnt_ff == 5'h07);

    // Fields of the completed frame
    wire [6:0] acc_addr = shift_ff[srm_pkg::ADDR_BITS-1:0];
    wire acc_write = shift_ff[srm_pkg::RW_BIT];
    wire [7:0] acc_data = shift_ff[srm_pkg::DATA_LSB +: srm_pkg::BYTE_BITS];
    // Only a frame of exactly 16 bits takes effect
    wire commit = cs_rise & (state_ff == srm_pkg::DEV_SHIFT)
        & (cnt_ff == 5'(srm_pkg::FRAME_BITS));

    // Read path: old contents go out, unmapped reads zero
    wire [5:0] rd_c = ctl_find(first_byte[6:0]);
    wire [4:0] rd_s = stat_find(first_byte[6:0]);
    wire rd_lvl = first_byte[6:0] == srm_pkg::ADDR_WAKE_LEVELS;
    wire rd_id = first_byte[6:0] == srm_pkg::ADDR_FAMILY_ID;
    wire [7:0] rd_byte = rd_c[5] ? ctl_ff[rd_c[4:0]] :
        rd_s[4] ? st_ff[rd_s[3:0]] :
        rd_lvl ? lvl_ff :
        rd_id ? FAM_PROD_ID : 8'h00;

    // Commit path lookups
    wire [5:0] wr_c = ctl_find(acc_addr);
    wire [4:0] wr_s = stat_find(acc_addr);
    wire mode_wr = commit & acc_write & wr_c[5]
        & (wr_c[4:0] == 5'(srm_pkg::MODE_SUPPLY_IDX));
    wire soft_req = mode_wr
        & (acc_data[srm_pkg::MODE_MSB:srm_pkg::MODE_LSB] == srm_pkg::MODE_SOFT_RESET);

    // Control registers: soft reset, then restart, then updates
    for (genvar i = 0; i < NC; i++) begin : g_ctl
        wire host_wr = commit & acc_write & wr_c[5] & (wr_c[4:0] == 5'(i));
        wire hw_wr = HW_UPD_VALID & (HW_UPD_IDX == 5'(i));
        wire [7:0] wmask = srm_pkg::CTRL_MASK[i];
        wire [7:0] hmask = srm_pkg::CTRL_HW_MASK[i];
        wire [7:0] after_host = host_wr ? (acc_data & wmask) : ctl_ff[i];
        // Device update reaches only its own bits; it wins a same-cycle clash
        wire [7:0] after_hw = hw_wr ? ((after_host & ~hmask) | (HW_UPD_DATA & hmask))
            : after_host;
        assign nxt_ctl[i] = soft_rst_ff ? srm_pkg::CTRL_POR[i] :
            RESTART ? (ctl_ff[i] & srm_pkg::CTRL_KEEP[i]) : after_hw;
        assign CTRL_OUT[i*8 +: 8] = ctl_ff[i];

        always_ff @(posedge CLK or negedge RESET_N) begin
            if (!RESET_N) begin
                ctl_ff[i] <= srm_pkg::CTRL_POR[i];
            end else if (CE) begin
                ctl_ff[i] <= nxt_ctl[i];
            end
        end
    end

    // Status registers: a new event wins over the clear by a read
    for (genvar i = 0; i < NS; i++) begin : g_st
        wire [7:0] set = STAT_SET[i*8 +: 8] & srm_pkg::STAT_MASK[i];
        wire clr = commit & ~acc_write & wr_s[4] & (wr_s[3:0] == 4'(i));
        assign nxt_st[i] = soft_rst_ff ? (srm_pkg::STAT_POR[i] | set) :
            ((clr ? 8'h00 : st_ff[i]) | set);

        always_ff @(posedge CLK or negedge RESET_N) begin
            if (!RESET_N) begin
                st_ff[i] <= srm_pkg::STAT_POR[i];
            end else if (CE) begin
                st_ff[i] <= nxt_st[i];
            end
        end
    end

    // Two-flop synchronisers plus one history stage for edges
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sclk_sy_ff <= 3'h0;
            cs_sy_ff <= 3'h7;
            mosi_sy_ff <= 2'h0;
        end else if (CE) begin
            sclk_sy_ff <= {sclk_sy_ff[1:0], LINK.sclk};
            cs_sy_ff <= {cs_sy_ff[1:0], LINK.cs_n};
            mosi_sy_ff <= {mosi_sy_ff[0], LINK.mosi};
        end
    end

    // Frame receiver and reply shifter
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_ff <= srm_pkg::DEV_IDLE;
            shift_ff <= 16'h0000;
            cnt_ff <= 5'h00;
            tx_ff <= 8'h00;
            miso_ff <= 1'b0;
        end else if (CE) begin
            if (cs_fall) begin
                state_ff <= srm_pkg::DEV_SHIFT;
                cnt_ff <= 5'h00;
                tx_ff <= 8'h00; // First byte of the reply is all zero
                miso_ff <= 1'b0;
            end else if (cs_rise) begin
                state_ff <= srm_pkg::DEV_IDLE;
            end else if (shifting && sclk_rise) begin
                shift_ff <= {mosi_sy_ff[1], shift_ff[15:1]};
                cnt_ff <= (cnt_ff == 5'h1F) ? cnt_ff : cnt_ff + 5'h01;
                if (addr_done) begin
                    tx_ff <= rd_byte; // Value before this frame's write
                end
            end else if (shifting && sclk_fall) begin
                miso_ff <= tx_ff[0];
                tx_ff <= {1'b0, tx_ff[7:1]};
            end
        end
    end

    // Soft reset pulse; wake levels come from pins, so two flops before use
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            soft_rst_ff <= 1'b0;
            lvl_sy_ff <= 8'h00;
            lvl_ff <= 8'h00;
        end else if (CE) begin
            soft_rst_ff <= soft_req;
            lvl_sy_ff <= WAKE_LEVELS;
            lvl_ff <= lvl_sy_ff & srm_pkg::WAKE_LEVELS_MASK;
        end
    end

    assign LINK.miso = miso_ff;
    assign SOFT_RESET_OUT = soft_rst_ff;
endmodule

// ### srm_host.sv
// Host end: APB command registers driving one serial frame at a time.
// Assumes software writes zero into reserved bits of the data it sends.
`timescale 1ns/1ps
module srm_host #(
    parameter int HALF = srm_pkg::SCLK_HALF_CYCLES
) (
    // Clock, reset, enable
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic CE,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Serial link
    srm_link_if.host LINK
);
    srm_pkg::srm_hst_state_t state_ff;
    logic [7:0] div_ff;
    logic [3:0] bit_ff;
    logic [15:0] tx_ff;
    logic [15:0] rx_ff;
    logic [15:0] cmd_ff;
    logic sclk_ff;
    logic cs_n_ff;
    logic mosi_ff;
    logic [1:0] miso_sy_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;

    // APB decode; one wait state before the answer
    wire apb_acc = PSEL & PENABLE & ~pready_ff;
    wire hit_cmd = PADDR == srm_pkg::APB_CMD_OFS;
    wire hit_stat = PADDR == srm_pkg::APB_STATUS_OFS;
    wire busy = state_ff != srm_pkg::HST_IDLE;
    wire start = apb_acc & PWRITE & hit_cmd & ~busy;
    wire bad = ~(hit_cmd | hit_stat) | (PWRITE & hit_cmd & busy);
    wire [31:0] stat_word = {16'h0000, rx_ff[15:8], 7'h00, busy};
    wire [31:0] rd_word = hit_stat ? stat_word : hit_cmd ? {16'h0000, cmd_ff} : 32'h0000_0000;
    wire tick = div_ff == 8'(HALF - 1);

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            miso_sy_ff <= 2'h0;
        end else if (CE) begin
            pready_ff <= apb_acc;
            pslverr_ff <= apb_acc & bad;
            prdata_ff <= (apb_acc & ~PWRITE) ? rd_word : 32'h0000_0000;
            miso_sy_ff <= {miso_sy_ff[0], LINK.miso};
        end
    end

    // Frame sequencer: clock divided from CLK, LSB first, mode 0
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_ff <= srm_pkg::HST_IDLE;
            div_ff <= 8'h00;
            bit_ff <= 4'h0;
            tx_ff <= 16'h0000;
            rx_ff <= 16'h0000;
            cmd_ff <= 16'h0000;
            sclk_ff <= 1'b0;
            cs_n_ff <= 1'b1;
            mosi_ff <= 1'b0;
        end else if (CE) begin
            div_ff <= (busy && !tick) ? div_ff + 8'h01 : 8'h00;
            case (state_ff)
                srm_pkg::HST_IDLE: begin
                    if (start) begin
                        // Address and write bit in byte 0, data in byte 1
                        cmd_ff <= PWDATA[15:0];
                        tx_ff <= PWDATA[15:0];
                        mosi_ff <= PWDATA[0];
                        cs_n_ff <= 1'b0;
                        bit_ff <= 4'h0;
                        state_ff <= srm_pkg::HST_LOW;
                    end
                end
                srm_pkg::HST_LOW: begin
                    if (tick) begin
                        sclk_ff <= 1'b1;
                        state_ff <= srm_pkg::HST_HIGH;
                    end
                end
                srm_pkg::HST_HIGH: begin
                    if (tick) begin
                        // Sample late in the high phase, after the reply settles
                        sclk_ff <= 1'b0;
                        rx_ff <= {miso_sy_ff[1], rx_ff[15:1]};
                        tx_ff <= {1'b0, tx_ff[15:1]};
                        mosi_ff <= tx_ff[1];
                        bit_ff <= bit_ff + 4'h1;
                        state_ff <= (bit_ff == 4'hF) ? srm_pkg::HST_TAIL : srm_pkg::HST_LOW;
                    end
                end
                srm_pkg::HST_TAIL: begin
                    if (tick) begin
                        cs_n_ff <= 1'b1;
                        state_ff <= srm_pkg::HST_GAP;
                    end
                end
                srm_pkg::HST_GAP: begin
                    if (tick) begin
                        state_ff <= srm_pkg::HST_IDLE;
                    end
                end
                default: begin
                    state_ff <= srm_pkg::HST_IDLE;
                end
            endcase
        end
    end

    assign PREADY = pready_ff;
    assign PSLVERR = pslverr_ff;
    assign PRDATA = prdata_ff;
    assign LINK.sclk = sclk_ff;
    assign LINK.cs_n = cs_n_ff;
    assign LINK.mosi = mosi_ff;
endmodule

// ### srm_link_if.sv
// Serial link between the register-map device and its host controller.
// Assumes the host drives clock, select and data out; the device drives back.
`timescale 1ns/1ps
interface srm_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    modport dev (input sclk, input cs_n, input mosi, output miso);
    modport host (output sclk, output cs_n, output mosi, input miso);
endinterface

// ### srm_link_sva.sv
// Checker for the serial link between the register-map host and device.
// Assumes it watches the link interface signals directly; HALF is 4.
`timescale 1ns/1ps
module srm_link_sva (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Link signals
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso
);
    default clocking dc @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    logic sclk_ff;
    logic [5:0] rises_ff;
    logic [5:0] nxt_rises;
    wire sclk_rise = sclk && !sclk_ff;
    // Rising link edges in the current frame; cleared while deselected
    assign nxt_rises = cs_n ? 6'h00 : (sclk_rise ? rises_ff + 6'h01 : rises_ff);

    // Edge detector and frame bit counter
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sclk_ff <= 1'b0;
            rises_ff <= 6'h00;
        end else begin
            sclk_ff <= sclk;
            rises_ff <= nxt_rises;
        end
    end

    property p_idle_low; cs_n |-> !sclk; endproperty
    property p_high_time; $rose(sclk) |-> sclk [*4] ##1 !sclk; endproperty
    property p_low_time; $fell(sclk) |-> !sclk [*4]; endproperty
    property p_lead; $fell(cs_n) |-> !sclk [*4] ##1 sclk; endproperty
    property p_bit_count; $rose(cs_n) |-> rises_ff == 6'h10; endproperty
    property p_mosi_stable; sclk |-> $stable(mosi); endproperty
    property p_miso_stable; sclk |-> $stable(miso); endproperty
    property p_gap; $rose(cs_n) |-> cs_n [*4]; endproperty
    property p_first_byte_zero;
        $rose(sclk) && rises_ff != 6'h00 && rises_ff < 6'h08 |-> !miso;
    endproperty

    a_idle_low: assert property (p_idle_low)
        else $error("link clock high outside a frame");
    a_high_time: assert property (p_high_time)
        else $error("link clock high phase not four cycles");
    a_low_time: assert property (p_low_time)
        else $error("link clock low phase too short");
    a_lead: assert property (p_lead)
        else $error("first link edge not four cycles after select");
    a_bit_count: assert property (p_bit_count)
        else $error("frame without exactly sixteen bits");
    a_mosi_stable: assert property (p_mosi_stable)
        else $error("host data moved while link clock high");
    a_miso_stable: assert property (p_miso_stable)
        else $error("device data moved while link clock high");
    a_gap: assert property (p_gap)
        else $error("deselect gap shorter than four cycles");
    a_first_byte_zero: assert property (p_first_byte_zero)
        else $error("device reply first byte not zero");

    c_frame: cover property ($rose(cs_n));
    c_write: cover property ($rose(sclk) && rises_ff == 6'h07 && mosi);
    c_read: cover property ($rose(sclk) && rises_ff == 6'h07 && !mosi);
endmodule

// ### srm_pkg.sv
// Shared constants for the serial register map: frame layout, register
// tables, reset and restart values, timing counts and state types.
// Assumes both link ends and the bench use every name through srm_pkg::.
package srm_pkg;
    // Frame layout: address byte first, then the data byte
    localparam int FRAME_BITS = 16;
    localparam int ADDR_BITS = 7;
    localparam int RW_BIT = 7;
    localparam int DATA_LSB = 8;
    localparam int BYTE_BITS = 8;

    // Control registers, read/write
    localparam int NUM_CTRL = 19;
    localparam logic [6:0] CTRL_ADDR [NUM_CTRL] = '{
        7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08, 7'h09, 7'h0C,
        7'h0D, 7'h10, 7'h14, 7'h15, 7'h17, 7'h18, 7'h19, 7'h1C, 7'h1E};
    // Implemented bits; the rest are reserved and read zero
    localparam logic [7:0] CTRL_MASK [NUM_CTRL] = '{
        8'hFF, 8'hFB, 8'hF7, 8'hFB, 8'h20, 8'hC4, 8'hA7, 8'h3F, 8'h3F, 8'h77,
        8'h77, 8'h70, 8'h77, 8'h77, 8'hFF, 8'hFF, 8'hFF, 8'h05, 8'hFF};
    // Bits the device itself may update
    localparam logic [7:0] CTRL_HW_MASK [NUM_CTRL] = '{
        8'hFC, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    // Power-on and soft reset values
    localparam logic [7:0] CTRL_POR [NUM_CTRL] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    // Bits left unchanged on restart; all other bits restart to zero
    localparam logic [7:0] CTRL_KEEP [NUM_CTRL] = '{
        8'h23, 8'hD9, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

    // Status registers, cleared by a read frame
    localparam int NUM_STAT = 10;
    localparam logic [6:0] STAT_ADDR [NUM_STAT] = '{
        7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46, 7'h47, 7'h54, 7'h55};
    localparam logic [7:0] STAT_MASK [NUM_STAT] = '{
        8'h5F, 8'hFF, 8'h07, 8'hCF, 8'h67, 8'h00, 8'h77, 8'h30, 8'h0F, 8'h0F};
    // Power-on flag stands set after reset
    localparam logic [7:0] STAT_POR [NUM_STAT] = '{
        8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    // Plain read-only registers
    localparam logic [6:0] ADDR_WAKE_LEVELS = 7'h48;
    localparam logic [7:0] WAKE_LEVELS_MASK = 8'hE7;
    localparam logic [6:0] ADDR_FAMILY_ID = 7'h7E;

    // Mode field of the first control register
    localparam int MODE_SUPPLY_IDX = 0;
    localparam int MODE_MSB = 7;
    localparam int MODE_LSB = 6;
    localparam logic [1:0] MODE_SOFT_RESET = 2'h3;

    // Host command registers on APB
    localparam logic [7:0] APB_CMD_OFS = 8'h00;
    localparam logic [7:0] APB_STATUS_OFS = 8'h04;
    localparam int CMD_WR_BIT = 7;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_RDATA_LSB = 8;

    // Link timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int SCLK_PERIOD_NS = 200;
    localparam int SCLK_HALF_CYCLES = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

    typedef enum logic {DEV_IDLE, DEV_SHIFT} srm_dev_state_t;
    typedef enum logic [2:0] {HST_IDLE, HST_LOW, HST_HIGH, HST_TAIL, HST_GAP} srm_hst_state_t;
endpackage

// ### tb_spi_register_map_access.sv
// Bench joining host and device ends over the link, driven through APB.
// Assumes host CMD/STATUS offsets and busy polling as in srm_pkg.
`timescale 1ns/1ps
module tb_spi_register_map_access;
    localparam logic [7:0] FAM_ID = 8'hA5; // Arbitrary identity value
    logic clk, rst_n, ce, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, d, wake_levels, hw_upd_data;
    logic [31:0] pwdata, prdata, r, seed = 32'h49207E29;
    logic hw_upd_valid, restart, soft_reset_out, e;
    logic [4:0] hw_upd_idx;
    logic [srm_pkg::NUM_STAT*8-1:0] stat_set;
    logic [srm_pkg::NUM_CTRL*8-1:0] ctrl_out;
    logic [7:0] ctrl_exp [srm_pkg::NUM_CTRL];
    logic [7:0] stat_exp [srm_pkg::NUM_STAT];
    int n_errors = 0;
    int samples_checked = 0;
    int n_soft = 0;

    srm_link_if link();
    srm_device #(.FAM_PROD_ID(FAM_ID)) srm_device_i (.CLK(clk), .RESET_N(rst_n), .CE(ce),
        .LINK(link), .HW_UPD_VALID(hw_upd_valid), .HW_UPD_IDX(hw_upd_idx),
        .HW_UPD_DATA(hw_upd_data), .RESTART(restart), .STAT_SET(stat_set),
        .WAKE_LEVELS(wake_levels), .CTRL_OUT(ctrl_out), .SOFT_RESET_OUT(soft_reset_out));
    srm_host #(.HALF(4)) srm_host_i (.CLK(clk), .RESET_N(rst_n), .CE(ce), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .LINK(link));
    srm_link_sva srm_link_sva_i (.CLK(clk), .RESET_N(rst_n), .sclk(link.sclk),
        .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso));

    // Free-running bench clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Soft reset pulses, counted for a later compare
    always @(posedge clk) begin
        if (soft_reset_out === 1'b1) n_soft <= n_soft + 1;
    end

    // Bench LFSR; fixed start value keeps runs repeatable
    function void rnd(output logic [7:0] v);
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        v = seed[7:0];
    endfunction

    // Reply expected from the model; unmapped places read zero
    function logic [7:0] exp_rd(input logic [6:0] a);
        logic [7:0] v;
        v = 8'h00;
        for (int i = 0; i < srm_pkg::NUM_CTRL; i++) if (a == srm_pkg::CTRL_ADDR[i]) v = ctrl_exp[i];
        for (int i = 0; i < srm_pkg::NUM_STAT; i++) if (a == srm_pkg::STAT_ADDR[i]) v = stat_exp[i];
        if (a == srm_pkg::ADDR_WAKE_LEVELS) v = wake_levels & srm_pkg::WAKE_LEVELS_MASK;
        if (a == srm_pkg::ADDR_FAMILY_ID) v = FAM_ID;
        return v;
    endfunction

    function logic [srm_pkg::NUM_CTRL*8-1:0] pack();
        logic [srm_pkg::NUM_CTRL*8-1:0] p;
        for (int i = 0; i < srm_pkg::NUM_CTRL; i++) p[8*i +: 8] = ctrl_exp[i];
        return p;
    endfunction

    task finish_test();
        if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task chk(input logic [151:0] seen, input logic [151:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; the request stands until ready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_errors++;
            finish_test();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // One link frame, reply and register outputs compared with the model
    task frame(input logic w, input logic [6:0] a, input logic [7:0] wd);
        int n;
        apb(1'b1, srm_pkg::APB_CMD_OFS, {16'h0000, wd, w, a});
        n = 0;
        do begin
            apb(1'b0, srm_pkg::APB_STATUS_OFS, 32'h0);
            n++;
        end while (r[srm_pkg::STATUS_BUSY_BIT] !== 1'b0 && n < 100);
        if (r[srm_pkg::STATUS_BUSY_BIT] !== 1'b0) begin
            n_errors++;
            finish_test();
        end
        chk(r[15:8], exp_rd(a));
        for (int i = 0; i < srm_pkg::NUM_CTRL; i++)
            if (w && a == srm_pkg::CTRL_ADDR[i]) ctrl_exp[i] = wd & srm_pkg::CTRL_MASK[i];
        for (int i = 0; i < srm_pkg::NUM_STAT; i++)
            if (!w && a == srm_pkg::STAT_ADDR[i]) stat_exp[i] = 8'h00;
        if (w && a == 7'h01 && wd[7:6] == srm_pkg::MODE_SOFT_RESET) begin
            ctrl_exp = srm_pkg::CTRL_POR;
            stat_exp = srm_pkg::STAT_POR;
        end
        chk(ctrl_out, pack());
    endtask

    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        hw_upd_valid = 1'b0;
        hw_upd_idx = 5'h00;
        hw_upd_data = 8'h00;
        restart = 1'b0;
        stat_set = '0;
        wake_levels = 8'h00;
        ctrl_exp = srm_pkg::CTRL_POR;
        stat_exp = srm_pkg::STAT_POR;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        // Random write to every control register, each read back at once with junk data
        for (int i = 0; i < srm_pkg::NUM_CTRL; i++) begin
            rnd(d);
            d = d & srm_pkg::CTRL_MASK[i];
            if (i == 0) d[7] = 1'b0;
            frame(1'b1, srm_pkg::CTRL_ADDR[i], d);
            rnd(d);
            frame(1'b0, srm_pkg::CTRL_ADDR[i], d);
        end
        // Device-side updates; only hardware-updatable bits may move
        for (int i = 0; i < 3; i++) begin
            rnd(d);
            d[7] = 1'b0;
            @(posedge clk);
            hw_upd_valid <= 1'b1;
            hw_upd_idx <= i[4:0];
            hw_upd_data <= d;
            @(posedge clk);
            hw_upd_valid <= 1'b0;
            ctrl_exp[i] = (ctrl_exp[i] & ~srm_pkg::CTRL_HW_MASK[i]) | (d & srm_pkg::CTRL_HW_MASK[i]);
            frame(1'b0, srm_pkg::CTRL_ADDR[i], 8'h00);
        end
        // Clock enable low: a device update in that cycle must not land
        @(posedge clk);
        ce <= 1'b0;
        hw_upd_valid <= 1'b1;
        hw_upd_idx <= 5'h00;
        hw_upd_data <= ~ctrl_exp[0] & 8'h7C;
        @(posedge clk);
        ce <= 1'b1;
        hw_upd_valid <= 1'b0;
        frame(1'b0, srm_pkg::CTRL_ADDR[0], 8'h00);
        // Power-on flags, then sticky flags: a write keeps them, a read clears
        for (int i = 0; i < srm_pkg::NUM_STAT; i++) begin
            frame(1'b0, srm_pkg::STAT_ADDR[i], 8'hFF);
            rnd(d);
            @(posedge clk);
            stat_set[8*i +: 8] <= d;
            @(posedge clk);
            stat_set <= '0;
            stat_exp[i] = d & srm_pkg::STAT_MASK[i];
            frame(1'b1, srm_pkg::STAT_ADDR[i], 8'h00);
            frame(1'b0, srm_pkg::STAT_ADDR[i], 8'h00);
            frame(1'b0, srm_pkg::STAT_ADDR[i], 8'h00);
        end
        // Read-only and unmapped places
        rnd(d);
        wake_levels <= d;
        frame(1'b1, srm_pkg::ADDR_WAKE_LEVELS, 8'hFF);
        frame(1'b0, srm_pkg::ADDR_FAMILY_ID, 8'h00);
        frame(1'b1, 7'h0A, 8'h55);
        frame(1'b0, 7'h0A, 8'h00);
        frame(1'b0, 7'h7F, 8'h00);
        apb(1'b0, 8'h08, 32'h0);
        chk(e, 1'b1);
        chk(r, 32'h0);
        // Command register reads back the last frame sent
        apb(1'b0, srm_pkg::APB_CMD_OFS, 32'h0);
        chk({e, r}, {1'b0, 32'h0000_007F});
        // Restart clears all but the kept bits
        @(posedge clk);
        restart <= 1'b1;
        @(posedge clk);
        restart <= 1'b0;
        for (int i = 0; i < srm_pkg::NUM_CTRL; i++) ctrl_exp[i] &= srm_pkg::CTRL_KEEP[i];
        frame(1'b0, 7'h01, 8'h00);
        // Soft reset by mode write brings back every power-on value
        frame(1'b1, 7'h01, 8'hC0);
        chk(n_soft, 1);
        frame(1'b0, 7'h41, 8'h00);
        finish_test();
    end
endmodule
